/* File: pbu_defines.vh */
`ifndef PBU_DEFINES_VH
`define PBU_DEFINES_VH

// ****************************************************************
// Port state machine encoding (one-hot)
// ****************************************************************
`define PBU_STATE_W           4
`define PBU_ST_BLOCKED        4'h1
`define PBU_ST_LOCAL_UNBLOCK  4'h2
`define PBU_ST_REMOTE_UNBLOCK 4'h4
`define PBU_ST_OPERATIONAL    4'h8

`endif

/* File: pbu_exch_fsm.v */
`timescale 1ns/100ps
`include "pbu_defines.vh"

module pbu_exch_fsm (
    input  wire                    clk_i,
    input  wire                    srst_i,
    input  wire                    mgmt_unblock_request_i,
    input  wire                    mgmt_block_command_i,
    input  wire                    acc_unblock_element_i,
    input  wire                    acc_block_element_i,
    input  wire                    acc_block_request_element_i,
    output reg                     exch_unblock_element_o,
    output reg                     exch_block_element_o,
    output reg                     mgmt_unblock_request_o,
    output reg                     mgmt_unblock_indication_o,
    output reg                     mgmt_block_command_o,
    output reg                     mgmt_deferrable_block_request_o,
    output wire [`PBU_STATE_W-1:0] state_o
);

    localparam [`PBU_STATE_W-1:0] EXCH_STATE_BLOCKED        = `PBU_ST_BLOCKED;
    localparam [`PBU_STATE_W-1:0] EXCH_STATE_LOCAL_UNBLOCK  = `PBU_ST_LOCAL_UNBLOCK;
    localparam [`PBU_STATE_W-1:0] EXCH_STATE_REMOTE_UNBLOCK = `PBU_ST_REMOTE_UNBLOCK;
    localparam [`PBU_STATE_W-1:0] EXCH_STATE_OPERATIONAL    = `PBU_ST_OPERATIONAL;

    reg [`PBU_STATE_W-1:0] state_r;
    reg [`PBU_STATE_W-1:0] state_nxt;
    reg                    ub_el_nxt;
    reg                    blk_el_nxt;
    reg                    ubr_nxt;
    reg                    ubi_nxt;
    reg                    bi_nxt;
    reg                    br_nxt;

    assign state_o = state_r;

    // ****************************************************************
    // Next state; one event per cycle, management block first
    // ****************************************************************
    always @* begin
        state_nxt  = state_r;
        ub_el_nxt  = 1'b0;
        blk_el_nxt = 1'b0;
        ubr_nxt    = 1'b0;
        ubi_nxt    = 1'b0;
        bi_nxt     = 1'b0;
        br_nxt     = 1'b0;
        if (mgmt_block_command_i) begin
            blk_el_nxt = 1'b1;
            state_nxt  = EXCH_STATE_BLOCKED;
        end else if (acc_block_element_i) begin
            if (state_r != EXCH_STATE_BLOCKED) begin
                bi_nxt    = 1'b1;
                state_nxt = EXCH_STATE_BLOCKED;
            end
        end else if (mgmt_unblock_request_i) begin
            ub_el_nxt = 1'b1;
            case (state_r)
                EXCH_STATE_BLOCKED: begin
                    state_nxt = EXCH_STATE_LOCAL_UNBLOCK;
                end
                EXCH_STATE_REMOTE_UNBLOCK: begin
                    ubi_nxt   = 1'b1;
                    state_nxt = EXCH_STATE_OPERATIONAL;
                end
                default: begin
                    state_nxt = state_r;
                end
            endcase
        end else if (acc_unblock_element_i) begin
            case (state_r)
                EXCH_STATE_BLOCKED: begin
                    ubr_nxt   = 1'b1;
                    state_nxt = EXCH_STATE_REMOTE_UNBLOCK;
                end
                EXCH_STATE_LOCAL_UNBLOCK: begin
                    ubi_nxt   = 1'b1;
                    state_nxt = EXCH_STATE_OPERATIONAL;
                end
                EXCH_STATE_REMOTE_UNBLOCK: begin
                    ubr_nxt = 1'b1;
                end
                default: begin
                    ubi_nxt = 1'b1;
                end
            endcase
        end else if (acc_block_request_element_i) begin
            // Outside operational this is unexpected and dropped
            if (state_r == EXCH_STATE_OPERATIONAL) begin
                br_nxt = 1'b1;
            end
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            state_r                         <= EXCH_STATE_BLOCKED;
            exch_unblock_element_o          <= 1'b0;
            exch_block_element_o            <= 1'b0;
            mgmt_unblock_request_o          <= 1'b0;
            mgmt_unblock_indication_o       <= 1'b0;
            mgmt_block_command_o            <= 1'b0;
            mgmt_deferrable_block_request_o <= 1'b0;
        end else begin
            state_r                         <= state_nxt;
            exch_unblock_element_o          <= ub_el_nxt;
            exch_block_element_o            <= blk_el_nxt;
            mgmt_unblock_request_o          <= ubr_nxt;
            mgmt_unblock_indication_o       <= ubi_nxt;
            mgmt_block_command_o            <= bi_nxt;
            mgmt_deferrable_block_request_o <= br_nxt;
        end
    end

endmodule

/* File: pbu_port_ctrl.v */
`timescale 1ns/100ps
`include "pbu_defines.vh"

// Overview of operation
// - Exchange unblock request: send element, local unblock
// - Access gets exchange unblock: remote, request upward
// - Access unblock request outside operational: send element, advance state except in local unblock
// - Exchange local unblock plus ack: operational
// - Unblock handshake symmetric, either side starts
// - Remote unblock plus peer block: blocked
// - Exchange remote unblock plus request: operational
// - Access on exchange unblock: remote or operational
// - Access on exchange block: indicate, blocked
// - Access block command: send element, blocked
// - Operational deferrable request sends element, state unchanged
// - Operational access unblock request answered locally
// - Operational exchange unblock request re-sends element
// - Undefined events ignored, state unchanged
// - Exchange block command: send element, blocked
// - Exchange forwards access block request upward
// - Indicate entry to and exit from operational

module pbu_port_ctrl (
    input  wire                    clk_i,
    input  wire                    srst_i,
    // Access side management
    input  wire                    acc_mgmt_unblock_request_i,
    input  wire                    acc_mgmt_block_command_i,
    input  wire                    acc_mgmt_deferrable_block_request_i,
    output reg                     acc_mgmt_unblock_request_o,
    output reg                     acc_mgmt_unblock_indication_o,
    output reg                     acc_mgmt_block_command_o,
    output reg                     acc_mgmt_status_valid_o,
    output reg                     acc_mgmt_status_operational_o,
    // Access side elements to and from the exchange peer
    input  wire                    exch_unblock_element_i,
    input  wire                    exch_block_element_i,
    output reg                     acc_unblock_element_o,
    output reg                     acc_block_element_o,
    output reg                     acc_block_request_element_o,
    output wire [`PBU_STATE_W-1:0] acc_state_o,
    // Exchange side management
    input  wire                    exch_mgmt_unblock_request_i,
    input  wire                    exch_mgmt_block_command_i,
    output wire                    exch_mgmt_unblock_request_o,
    output wire                    exch_mgmt_unblock_indication_o,
    output wire                    exch_mgmt_block_command_o,
    output wire                    exch_mgmt_deferrable_block_request_o,
    // Exchange side elements to and from the access peer
    input  wire                    acc_unblock_element_i,
    input  wire                    acc_block_element_i,
    input  wire                    acc_block_request_element_i,
    output wire                    exch_unblock_element_o,
    output wire                    exch_block_element_o,
    output wire [`PBU_STATE_W-1:0] exch_state_o
);

    localparam [`PBU_STATE_W-1:0] ACC_STATE_BLOCKED        = `PBU_ST_BLOCKED;
    localparam [`PBU_STATE_W-1:0] ACC_STATE_LOCAL_UNBLOCK  = `PBU_ST_LOCAL_UNBLOCK;
    localparam [`PBU_STATE_W-1:0] ACC_STATE_REMOTE_UNBLOCK = `PBU_ST_REMOTE_UNBLOCK;
    localparam [`PBU_STATE_W-1:0] ACC_STATE_OPERATIONAL    = `PBU_ST_OPERATIONAL;

    reg [`PBU_STATE_W-1:0] state_r;
    reg [`PBU_STATE_W-1:0] state_nxt;
    reg                    ub_el_nxt;
    reg                    blk_el_nxt;
    reg                    br_el_nxt;
    reg                    ubr_nxt;
    reg                    ubi_nxt;
    reg                    bi_nxt;
    reg                    stat_nxt;

    assign acc_state_o = state_r;

    // ****************************************************************
    // Exchange side machine
    // ****************************************************************
    pbu_exch_fsm u_exch (
        .clk_i                           (clk_i),
        .srst_i                          (srst_i),
        .mgmt_unblock_request_i          (exch_mgmt_unblock_request_i),
        .mgmt_block_command_i            (exch_mgmt_block_command_i),
        .acc_unblock_element_i           (acc_unblock_element_i),
        .acc_block_element_i             (acc_block_element_i),
        .acc_block_request_element_i     (acc_block_request_element_i),
        .exch_unblock_element_o          (exch_unblock_element_o),
        .exch_block_element_o            (exch_block_element_o),
        .mgmt_unblock_request_o          (exch_mgmt_unblock_request_o),
        .mgmt_unblock_indication_o       (exch_mgmt_unblock_indication_o),
        .mgmt_block_command_o            (exch_mgmt_block_command_o),
        .mgmt_deferrable_block_request_o (exch_mgmt_deferrable_block_request_o),
        .state_o                         (exch_state_o)
    );

    // ****************************************************************
    // Access side event arbitration
    // ****************************************************************
    // One-hot winner of the access events. Losers of the same cycle are
    // dropped, so management must not stack requests into one cycle.
    function [4:0] acc_event_pick;
        input blk_cmd;
        input peer_blk;
        input unblk_req;
        input peer_unblk;
        input defer_req;
        begin
            acc_event_pick = 5'h00;
            if (blk_cmd) begin
                acc_event_pick = 5'h10;
            end else if (peer_blk) begin
                acc_event_pick = 5'h08;
            end else if (unblk_req) begin
                acc_event_pick = 5'h04;
            end else if (peer_unblk) begin
                acc_event_pick = 5'h02;
            end else if (defer_req) begin
                acc_event_pick = 5'h01;
            end
        end
    endfunction

    wire [4:0] acc_ev;

    assign acc_ev = acc_event_pick(acc_mgmt_block_command_i, exch_block_element_i, acc_mgmt_unblock_request_i,
                                   exch_unblock_element_i, acc_mgmt_deferrable_block_request_i);

    // ****************************************************************
    // Access side next state
    // ****************************************************************
    // Priority: local block, peer block, local unblock, peer unblock,
    // deferrable request. Blocking wins so a port never unblocks late.
    always @* begin
        state_nxt  = state_r;
        ub_el_nxt  = 1'b0;
        blk_el_nxt = 1'b0;
        br_el_nxt  = 1'b0;
        ubr_nxt    = 1'b0;
        ubi_nxt    = 1'b0;
        bi_nxt     = 1'b0;
        stat_nxt   = 1'b0;
        if (acc_ev[4]) begin
            blk_el_nxt = 1'b1;
            state_nxt  = ACC_STATE_BLOCKED;
        end else if (acc_ev[3]) begin
            if (state_r != ACC_STATE_BLOCKED) begin
                bi_nxt    = 1'b1;
                state_nxt = ACC_STATE_BLOCKED;
            end
        end else if (acc_ev[2]) begin
            case (state_r)
                ACC_STATE_BLOCKED: begin
                    ub_el_nxt = 1'b1;
                    state_nxt = ACC_STATE_LOCAL_UNBLOCK;
                end
                ACC_STATE_LOCAL_UNBLOCK: begin
                    ub_el_nxt = 1'b1;
                end
                ACC_STATE_REMOTE_UNBLOCK: begin
                    ub_el_nxt = 1'b1;
                    ubi_nxt   = 1'b1;
                    state_nxt = ACC_STATE_OPERATIONAL;
                end
                default: begin
                    // Local status check, nothing goes to the peer
                    stat_nxt = 1'b1;
                end
            endcase
        end else if (acc_ev[1]) begin
            case (state_r)
                ACC_STATE_BLOCKED: begin
                    ubr_nxt   = 1'b1;
                    state_nxt = ACC_STATE_REMOTE_UNBLOCK;
                end
                ACC_STATE_LOCAL_UNBLOCK: begin
                    ubi_nxt   = 1'b1;
                    state_nxt = ACC_STATE_OPERATIONAL;
                end
                ACC_STATE_REMOTE_UNBLOCK: begin
                    ubr_nxt = 1'b1;
                end
                default: begin
                    // Verification from the exchange: re-acknowledge
                    ub_el_nxt = 1'b1;
                    ubi_nxt   = 1'b1;
                end
            endcase
        end else if (acc_ev[0]) begin
            // Only meaningful while operational, else ignored
            if (state_r == ACC_STATE_OPERATIONAL) begin
                br_el_nxt = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Access side registers
    // ****************************************************************
    always @(posedge clk_i) begin
        if (srst_i) begin
            state_r                       <= ACC_STATE_BLOCKED;
            acc_unblock_element_o         <= 1'b0;
            acc_block_element_o           <= 1'b0;
            acc_block_request_element_o   <= 1'b0;
            acc_mgmt_unblock_request_o    <= 1'b0;
            acc_mgmt_unblock_indication_o <= 1'b0;
            acc_mgmt_block_command_o      <= 1'b0;
            acc_mgmt_status_valid_o       <= 1'b0;
            acc_mgmt_status_operational_o <= 1'b0;
        end else begin
            state_r                       <= state_nxt;
            acc_unblock_element_o         <= ub_el_nxt;
            acc_block_element_o           <= blk_el_nxt;
            acc_block_request_element_o   <= br_el_nxt;
            acc_mgmt_unblock_request_o    <= ubr_nxt;
            acc_mgmt_unblock_indication_o <= ubi_nxt;
            acc_mgmt_block_command_o      <= bi_nxt;
            acc_mgmt_status_valid_o       <= stat_nxt;
            acc_mgmt_status_operational_o <= stat_nxt;
        end
    end

endmodule

/* File: pbu_peer_model.sv */
`timescale 1ns/100ps

// ****************************************************************
// Peer machine stand-in: loops elements across, or bench injects
// ****************************************************************
module pbu_peer_model (
    input  wire       loop_i,
    input  wire [4:0] inject_i,
    input  wire       xue_i,
    input  wire       xbe_i,
    input  wire       aue_i,
    input  wire       abe_i,
    input  wire       abre_i,
    output wire       xue_o,
    output wire       xbe_o,
    output wire       aue_o,
    output wire       abe_o,
    output wire       abre_o
);
    // Lines idle low between pulses; looped elements keep their own cycle
    assign xue_o  = (loop_i & xue_i) | inject_i[4];
    assign xbe_o  = (loop_i & xbe_i) | inject_i[3];
    assign aue_o  = (loop_i & aue_i) | inject_i[2];
    assign abe_o  = (loop_i & abe_i) | inject_i[1];
    assign abre_o = (loop_i & abre_i) | inject_i[0];
endmodule

/* File: pbu_port_ctrl_props.sv */
`timescale 1ns/100ps
`include "pbu_defines.vh"

module pbu_port_ctrl_props (
    input wire                    clk_i,
    input wire                    srst_i,
    input wire                    acc_mgmt_unblock_request_i,
    input wire                    acc_mgmt_block_command_i,
    input wire                    acc_mgmt_deferrable_block_request_i,
    input wire                    exch_unblock_element_i,
    input wire                    exch_block_element_i,
    input wire                    exch_mgmt_unblock_request_i,
    input wire                    exch_mgmt_block_command_i,
    input wire                    acc_unblock_element_i,
    input wire                    acc_block_element_i,
    input wire [`PBU_STATE_W-1:0] acc_state_o,
    input wire [`PBU_STATE_W-1:0] exch_state_o,
    input wire                    acc_mgmt_unblock_request_o,
    input wire                    acc_mgmt_block_command_o,
    input wire                    acc_block_element_o,
    input wire                    acc_block_request_element_o,
    input wire                    exch_unblock_element_o,
    input wire                    exch_block_element_o,
    input wire                    exch_mgmt_unblock_indication_o,
    input wire                    exch_mgmt_block_command_o
);
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // Higher-priority events absent, so the lower one is acted on
    sequence acc_calm;
        !acc_mgmt_block_command_i && !exch_block_element_i && !acc_mgmt_unblock_request_i;
    endsequence
    sequence exch_calm;
        !exch_mgmt_block_command_i && !acc_block_element_i && !exch_mgmt_unblock_request_i;
    endsequence
    reset_clear_a: assert property (disable iff (1'b0) srst_i |=>
        acc_state_o == `PBU_ST_BLOCKED && exch_state_o == `PBU_ST_BLOCKED && !exch_unblock_element_o
        && !acc_block_element_o) else $error("reset did not clear machines");
    exch_ub_start_a: assert property (exch_state_o == `PBU_ST_BLOCKED && exch_mgmt_unblock_request_i
        && !exch_mgmt_block_command_i && !acc_block_element_i |=> exch_unblock_element_o
        && exch_state_o == `PBU_ST_LOCAL_UNBLOCK) else $error("exchange unblock start wrong");
    exch_blk_cmd_a: assert property (exch_mgmt_block_command_i |=> exch_block_element_o
        && exch_state_o == `PBU_ST_BLOCKED) else $error("exchange block command wrong");
    acc_blk_cmd_a: assert property (acc_mgmt_block_command_i |=> acc_block_element_o
        && acc_state_o == `PBU_ST_BLOCKED) else $error("access block command wrong");
    acc_remote_ub_a: assert property (acc_calm ##0 (acc_state_o == `PBU_ST_BLOCKED
        && exch_unblock_element_i) |=> acc_mgmt_unblock_request_o && acc_state_o == `PBU_ST_REMOTE_UNBLOCK)
        else $error("access remote unblock wrong");
    acc_peer_blk_a: assert property (acc_state_o != `PBU_ST_BLOCKED && exch_block_element_i
        && !acc_mgmt_block_command_i |=> acc_mgmt_block_command_o && acc_state_o == `PBU_ST_BLOCKED)
        else $error("access peer block wrong");
    exch_ack_op_a: assert property (exch_calm ##0 (exch_state_o == `PBU_ST_LOCAL_UNBLOCK
        && acc_unblock_element_i) |=> exch_mgmt_unblock_indication_o && exch_state_o == `PBU_ST_OPERATIONAL)
        else $error("exchange acknowledge wrong");
    defer_req_a: assert property (acc_calm ##0 (acc_state_o == `PBU_ST_OPERATIONAL && !exch_unblock_element_i
        && acc_mgmt_deferrable_block_request_i) |=> acc_block_request_element_o && $stable(acc_state_o))
        else $error("deferrable request wrong");
    exch_unexp_a: assert property (exch_state_o == `PBU_ST_BLOCKED && acc_block_element_i
        && !exch_mgmt_block_command_i |=> exch_state_o == `PBU_ST_BLOCKED && !exch_mgmt_block_command_o)
        else $error("unexpected event changed state");
endmodule

bind pbu_port_ctrl pbu_port_ctrl_props u_props (.clk_i, .srst_i, .acc_mgmt_unblock_request_i,
    .acc_mgmt_block_command_i, .acc_mgmt_deferrable_block_request_i, .exch_unblock_element_i,
    .exch_block_element_i, .exch_mgmt_unblock_request_i, .exch_mgmt_block_command_i, .acc_unblock_element_i,
    .acc_block_element_i, .acc_state_o, .exch_state_o, .acc_mgmt_unblock_request_o, .acc_mgmt_block_command_o,
    .acc_block_element_o, .acc_block_request_element_o, .exch_unblock_element_o, .exch_block_element_o,
    .exch_mgmt_unblock_indication_o, .exch_mgmt_block_command_o);

/* File: pbu_port_ctrl_tb.sv */
`timescale 1ns/100ps
`include "pbu_defines.vh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module pbu_port_ctrl_tb;
    localparam [3:0] st_b = `PBU_ST_BLOCKED, st_l = `PBU_ST_LOCAL_UNBLOCK;
    localparam [3:0] st_r = `PBU_ST_REMOTE_UNBLOCK, st_o = `PBU_ST_OPERATIONAL;
    localparam [9:0] i_aubr = 10'h200, i_abc = 10'h100, i_adbr = 10'h080, i_xubr = 10'h040, i_xbc = 10'h020;
    localparam [9:0] i_xue = 10'h010, i_xbe = 10'h008, i_aue = 10'h004, i_abe = 10'h002, i_abre = 10'h001;
    localparam [13:0] m_aubr = 14'h2000, m_aubi = 14'h1000, m_abc = 14'h0800, m_asv = 14'h0400;
    localparam [13:0] m_aso = 14'h0200, m_aue = 14'h0100, m_abe = 14'h0080, m_abre = 14'h0040, m_xubr = 14'h0020;
    localparam [13:0] m_xubi = 14'h0010, m_xbc = 14'h0008, m_xdbr = 14'h0004, m_xue = 14'h0002, m_xbe = 14'h0001;
    logic       clk_i = 1'b0;
    logic       srst_i = 1'b1;
    logic       loop_en = 1'b0;
    logic [9:0] ins = 10'h000;
    int         n_fail = 0;
    int         comparisons = 0;
    wire acc_mgmt_unblock_request_i, acc_mgmt_block_command_i, acc_mgmt_deferrable_block_request_i;
    wire exch_mgmt_unblock_request_i, exch_mgmt_block_command_i, exch_unblock_element_i, exch_block_element_i;
    wire acc_unblock_element_i, acc_block_element_i, acc_block_request_element_i;
    wire acc_mgmt_unblock_request_o, acc_mgmt_unblock_indication_o, acc_mgmt_block_command_o;
    wire acc_mgmt_status_valid_o, acc_mgmt_status_operational_o, acc_unblock_element_o, acc_block_element_o;
    wire acc_block_request_element_o, exch_mgmt_unblock_request_o, exch_mgmt_unblock_indication_o;
    wire exch_mgmt_block_command_o, exch_mgmt_deferrable_block_request_o, exch_unblock_element_o;
    wire exch_block_element_o;
    wire [3:0] acc_state_o, exch_state_o;
    wire [13:0] outs = {acc_mgmt_unblock_request_o, acc_mgmt_unblock_indication_o, acc_mgmt_block_command_o,
        acc_mgmt_status_valid_o, acc_mgmt_status_operational_o, acc_unblock_element_o, acc_block_element_o,
        acc_block_request_element_o, exch_mgmt_unblock_request_o, exch_mgmt_unblock_indication_o,
        exch_mgmt_block_command_o, exch_mgmt_deferrable_block_request_o, exch_unblock_element_o,
        exch_block_element_o};
    assign {acc_mgmt_unblock_request_i, acc_mgmt_block_command_i, acc_mgmt_deferrable_block_request_i,
        exch_mgmt_unblock_request_i, exch_mgmt_block_command_i} = ins[9:5];

    pbu_port_ctrl dut (.clk_i, .srst_i, .acc_mgmt_unblock_request_i, .acc_mgmt_block_command_i,
        .acc_mgmt_deferrable_block_request_i, .acc_mgmt_unblock_request_o, .acc_mgmt_unblock_indication_o,
        .acc_mgmt_block_command_o, .acc_mgmt_status_valid_o, .acc_mgmt_status_operational_o,
        .exch_unblock_element_i, .exch_block_element_i, .acc_unblock_element_o, .acc_block_element_o,
        .acc_block_request_element_o, .acc_state_o, .exch_mgmt_unblock_request_i, .exch_mgmt_block_command_i,
        .exch_mgmt_unblock_request_o, .exch_mgmt_unblock_indication_o, .exch_mgmt_block_command_o,
        .exch_mgmt_deferrable_block_request_o, .acc_unblock_element_i, .acc_block_element_i,
        .acc_block_request_element_i, .exch_unblock_element_o, .exch_block_element_o, .exch_state_o);
    pbu_peer_model peer (.loop_i(loop_en), .inject_i(ins[4:0]), .xue_i(exch_unblock_element_o),
        .xbe_i(exch_block_element_o), .aue_i(acc_unblock_element_o), .abe_i(acc_block_element_o),
        .abre_i(acc_block_request_element_o), .xue_o(exch_unblock_element_i), .xbe_o(exch_block_element_i),
        .aue_o(acc_unblock_element_i), .abe_o(acc_block_element_i), .abre_o(acc_block_request_element_i));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // One input vector per call: apply at falling edge, taken at rising, judged a half cycle later
    task go(input [9:0] v, input [3:0] as, input [3:0] xs, input [13:0] o);
        ins = v;
        @(posedge clk_i);
        @(negedge clk_i);
        `CHK({acc_state_o, exch_state_o, outs}, {as, xs, o})
    endtask

    task finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task t_unexpected;
        go(i_adbr, st_b, st_b, 14'h0000);
        go(i_abre, st_b, st_b, 14'h0000);
        go(i_abe, st_b, st_b, 14'h0000);
        go(i_xbe, st_b, st_b, 14'h0000);
        go(i_abc | i_aubr, st_b, st_b, m_abe);
        go(i_xbc, st_b, st_b, m_xbe);
        $display("t_unexpected done");
    endtask

    task t_cancel;
        go(i_xue, st_r, st_b, m_aubr);
        go(i_xue, st_r, st_b, m_aubr);
        go(i_xbe, st_b, st_b, m_abc);
        go(i_aue, st_b, st_r, m_xubr);
        go(i_aue, st_b, st_r, m_xubr);
        go(i_abe, st_b, st_b, m_xbc);
        go(i_xubr, st_b, st_l, m_xue);
        go(i_xubr, st_b, st_l, m_xue);
        go(i_xbc, st_b, st_b, m_xbe);
        $display("t_cancel done");
    endtask

    task t_exch_unblock;
        go(i_xubr, st_b, st_l, m_xue);
        go(10'h000, st_r, st_l, m_aubr);
        go(i_aubr, st_o, st_l, m_aue | m_aubi);
        go(10'h000, st_o, st_o, m_xubi);
        go(i_xubr, st_o, st_o, m_xue);
        go(10'h000, st_o, st_o, m_aue | m_aubi);
        go(10'h000, st_o, st_o, m_xubi);
        go(i_aubr, st_o, st_o, m_asv | m_aso);
        $display("t_exch_unblock done");
    endtask

    task t_defer;
        go(i_adbr, st_o, st_o, m_abre);
        go(10'h000, st_o, st_o, m_xdbr);
        go(i_xbc, st_o, st_b, m_xbe);
        go(10'h000, st_b, st_b, m_abc);
        $display("t_defer done");
    endtask

    task t_acc_unblock;
        go(i_aubr, st_l, st_b, m_aue);
        go(10'h000, st_l, st_r, m_xubr);
        go(i_xubr, st_l, st_o, m_xue | m_xubi);
        go(10'h000, st_o, st_o, m_aubi);
        go(i_abc, st_b, st_o, m_abe);
        go(10'h000, st_b, st_b, m_xbc);
        $display("t_acc_unblock done");
    endtask

    // Reset taken mid-handshake, with a looped element still in flight
    task t_reset;
        go(i_aubr, st_l, st_b, m_aue);
        go(i_aubr, st_l, st_r, m_aue | m_xubr);
        srst_i = 1'b1;
        go(10'h000, st_b, st_b, 14'h0000);
        srst_i = 1'b0;
        go(10'h000, st_b, st_b, 14'h0000);
        $display("t_reset done");
    endtask

    initial begin
        #100000;
        n_fail++;
        finish_test;
    end

    initial begin
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        srst_i = 1'b0;
        go(10'h000, st_b, st_b, 14'h0000);
        t_unexpected;
        t_cancel;
        loop_en = 1'b1;
        t_exch_unblock;
        t_defer;
        t_acc_unblock;
        t_reset;
        finish_test;
    end
endmodule
